// ===== logic/uart_defines.vh
// Register offsets, field positions, reset values and bit timing for the serial port.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_DATA 6'h00
`define OFS_IER 6'h04
`define OFS_IIR_FCR 6'h08
`define OFS_LCR 6'h0C
`define OFS_MCR 6'h10
`define OFS_LSR 6'h14
`define OFS_DLL 6'h18
`define OFS_DLH 6'h1C
`define OFS_DLF 6'h20
`define OFS_LPL 6'h24
`define OFS_LPH 6'h28
`define OFS_MSR 6'h2C
`define LAST_INDEX 4'hB

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LCR_STOP2 2
`define LCR_PAR_EN 3
`define LCR_EVEN 4
`define LCR_BREAK 6
`define MCR_RTS 1
`define MCR_AUTOFLOW 5
`define MCR_SIR 6
`define MCR_LOWPOWER 7
`define IER_RDA 0
`define IER_TX_HOLDING_EMPTY 1
`define IER_LSI 2
`define IER_PTIME 7
`define FCR_FIFO_EN 0
`define FCR_RX_RST 1
`define FCR_TX_RST 2

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define IID_NONE 4'h1
`define IID_LINE 4'h6
`define IID_RDA 4'h4
`define IID_TIMEOUT 4'hC
`define IID_TX_HOLDING_EMPTY 4'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Bit timing in baud ticks
// ------------------------------------------------------------
`define TICKS_PER_BIT 6'h10
`define TICKS_STOP_HALF 6'h18
`define TICKS_STOP_TWO 6'h20
`define TICK_MID 4'h7
`define TICK_LAST 4'hF
`define SIR_PULSE_TICKS 6'h03
`define SIR_STRETCH 5'h10

`endif

// ===== logic/sir_uart.v
// Serial port with 16-deep FIFOs, fractional baud generator, flow control and infrared SIR coding.
// Assumes an AXI4-Lite master on aclk; serial pins arrive asynchronously and are synchronised here.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "uart_defines.vh"

module sir_uart #(
  parameter SIR_PRESENT = 1,
  parameter FIFO_DEPTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [5:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire rx_in,
  output reg tx_out,
  input wire sir_in,
  output reg sir_out_n,
  input wire cts_n,
  output reg rts_n,
  output reg baudout_n
);
  localparam PW = $clog2(FIFO_DEPTH);
  localparam [PW:0] DEPTH = FIFO_DEPTH[PW:0];
  localparam [2:0] TX_IDLE = 3'd0, TX_START = 3'd1, TX_DATA = 3'd2, TX_PAR = 3'd3, TX_STOP = 3'd4;
  localparam [2:0] RX_IDLE = 3'd0, RX_START = 3'd1, RX_DATA = 3'd2, RX_PAR = 3'd3, RX_STOP = 3'd4,
    RX_BRK = 3'd5;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {rx_in, sir_in, cts_n};
      sync2_q <= sync1_q;
    end
  end
  wire rx_s = sync2_q[2];
  wire sir_s = sync2_q[1];
  wire cts_n_s = sync2_q[0];

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  reg [7:0] ier_q, lcr_q, mcr_q, dll_q, dlh_q, lpl_q, lph_q;
  reg [3:0] dlf_q;
  reg fifo_en_q;
  reg [1:0] rx_trig_q, tx_thr_q;

  wire sir = (SIR_PRESENT != 0) && mcr_q[`MCR_SIR];
  wire [1:0] dbits = sir ? 2'h3 : lcr_q[1:0];
  // SIR ignores parity and stop setting
  wire par_en = !sir && lcr_q[`LCR_PAR_EN];
  wire stop2 = !sir && lcr_q[`LCR_STOP2];
  wire [2:0] last_bit = {1'b0, dbits} + 3'h4;
  wire [7:0] dmask = 8'hFF >> (2'h3 - dbits);
  // half stop only for five-bit 1.5 stop
  wire [5:0] stop_ticks = !stop2 ? `TICKS_PER_BIT : (dbits == 2'h0 ? `TICKS_STOP_HALF : `TICKS_STOP_TWO);
  wire autoflow = mcr_q[`MCR_AUTOFLOW];

  // ------------------------------------------------------------
  // Baud and low-power tick generators
  // ------------------------------------------------------------
  wire [15:0] div = {dlh_q, dll_q};
  wire [15:0] lpdiv = {lph_q, lpl_q};
  reg [15:0] bcnt_q, lpcnt_q;
  reg [3:0] facc_q;
  wire [4:0] fsum = {1'b0, facc_q} + {1'b0, dlf_q};
  wire tick = (div != 16'h0000) && (bcnt_q == 16'h0000);
  wire lptick = (lpdiv != 16'h0000) && (lpcnt_q == 16'h0000);
  always @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_q <= 16'h0000;
      facc_q <= 4'h0;
      lpcnt_q <= 16'h0000;
      baudout_n <= 1'b1;
    end else begin
      if (div == 16'h0000) begin
        bcnt_q <= 16'h0000;
      end else if (tick) begin
        facc_q <= fsum[3:0];
        bcnt_q <= div - 16'h0001 + {15'h0000, fsum[4]};
      end else begin
        bcnt_q <= bcnt_q - 16'h0001;
      end
      if (lpdiv == 16'h0000 || lptick) begin
        lpcnt_q <= (lpdiv == 16'h0000) ? 16'h0000 : lpdiv - 16'h0001;
      end else begin
        lpcnt_q <= lpcnt_q - 16'h0001;
      end
      baudout_n <= !tick;
    end
  end

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  reg aw_have_q, w_have_q;
  reg [5:0] aw_addr_q;
  reg [7:0] w_byte_q;
  reg w_en_q;
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign arready = !rvalid;
  wire wr_go = aw_have_q && w_have_q && !bvalid;
  wire rd_go = arvalid && !rvalid;
  wire wr_ok = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[5:2] <= `LAST_INDEX);
  wire rd_ok = (araddr[1:0] == 2'h0) && (araddr[5:2] <= `LAST_INDEX);
  wire wr_hit = wr_go && wr_ok && w_en_q;
  wire wr_data = wr_hit && aw_addr_q == `OFS_DATA;
  wire wr_fcr = wr_hit && aw_addr_q == `OFS_IIR_FCR;
  wire rd_data = rd_go && araddr == `OFS_DATA;
  wire rd_iir = rd_go && araddr == `OFS_IIR_FCR;
  wire rd_lsr = rd_go && araddr == `OFS_LSR;

  // ------------------------------------------------------------
  // FIFOs
  // ------------------------------------------------------------
  // separate sixteen-entry buffers
  reg [7:0] tx_mem [0:FIFO_DEPTH-1];
  reg [10:0] rx_mem [0:FIFO_DEPTH-1];
  reg [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg [PW:0] tx_cnt_q, rx_cnt_q;
  // With FIFOs off each path holds a single character, as a plain holding register
  wire [PW:0] cap = fifo_en_q ? DEPTH : {{PW{1'b0}}, 1'b1};
  wire tx_full = tx_cnt_q >= cap;
  wire rx_full = rx_cnt_q >= cap;
  wire tx_empty = tx_cnt_q == {(PW+1){1'b0}};
  wire rx_empty = rx_cnt_q == {(PW+1){1'b0}};
  wire tx_push = wr_data && !tx_full;
  wire tx_pop;
  wire rx_push;
  wire rx_pop = rd_data && !rx_empty;
  wire [10:0] rx_word;
  wire rx_rst = wr_fcr && (w_byte_q[`FCR_RX_RST] || w_byte_q[`FCR_FIFO_EN] != fifo_en_q);
  wire tx_rst = wr_fcr && (w_byte_q[`FCR_TX_RST] || w_byte_q[`FCR_FIFO_EN] != fifo_en_q);
  wire rx_take = rx_push && !rx_full;
  always @(posedge aclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= w_byte_q;
    end
    if (rx_take) begin
      rx_mem[rx_wp_q] <= rx_word;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn || tx_rst) begin
      tx_wp_q <= {PW{1'b0}};
      tx_rp_q <= {PW{1'b0}};
      tx_cnt_q <= {(PW+1){1'b0}};
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + {{PW{1'b0}}, tx_push} - {{PW{1'b0}}, tx_pop};
    end
  end
  always @(posedge aclk) begin
    if (!aresetn || rx_rst) begin
      rx_wp_q <= {PW{1'b0}};
      rx_rp_q <= {PW{1'b0}};
      rx_cnt_q <= {(PW+1){1'b0}};
    end else begin
      if (rx_take) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_q + {{PW{1'b0}}, rx_take} - {{PW{1'b0}}, rx_pop};
    end
  end
  wire [10:0] rx_head = rx_mem[rx_rp_q];

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  reg [2:0] tx_st_q, tx_bit_q;
  reg [5:0] tx_tick_q;
  reg [7:0] tx_sh_q;
  reg tx_par_q;
  wire rx_busy;
  wire [7:0] tx_head = tx_mem[tx_rp_q] & dmask;
  // with automatic flow control on, hold off while CTS is inactive
  // no transmit start while receiving in SIR
  assign tx_pop = (tx_st_q == TX_IDLE) && !tx_empty && !(autoflow && cts_n_s) && !(sir && rx_busy);
  wire tx_bit_end = tick && (tx_tick_q == `TICKS_PER_BIT - 6'h01);
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= TX_IDLE;
      tx_bit_q <= 3'h0;
      tx_tick_q <= 6'h00;
      tx_sh_q <= `RST_BYTE;
      tx_par_q <= 1'b0;
    end else begin
      if (tick) begin
        tx_tick_q <= tx_tick_q + 6'h01;
      end
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_sh_q <= tx_head;
            tx_par_q <= ^tx_head ^ !lcr_q[`LCR_EVEN];
            tx_tick_q <= 6'h00;
            tx_bit_q <= 3'h0;
            tx_st_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_tick_q <= 6'h00;
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_tick_q <= 6'h00;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == last_bit) begin
              tx_st_q <= par_en ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_tick_q <= 6'h00;
            tx_st_q <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tick && tx_tick_q == stop_ticks - 6'h01) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  wire tx_level = (tx_st_q == TX_START) ? 1'b0 : (tx_st_q == TX_DATA) ? tx_sh_q[0] :
    (tx_st_q == TX_PAR) ? tx_par_q : 1'b1;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_out <= 1'b1;
      sir_out_n <= 1'b1;
    end else begin
      // serial pin idles high in SIR
      tx_out <= sir ? 1'b1 : (tx_level && !lcr_q[`LCR_BREAK]);
      sir_out_n <= !(sir && !tx_level && tx_tick_q < `SIR_PULSE_TICKS);
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  reg [2:0] rx_st_q, rx_bit_q;
  reg [3:0] rx_tick_q;
  reg [7:0] rx_sh_q;
  reg [4:0] str_q;
  reg rx_par_q, rx_zero_q;
  // low-power mode samples on its own faster tick
  // short pulse caught by the faster tick
  wire sir_tick = mcr_q[`MCR_LOWPOWER] ? lptick : tick;
  // own infrared echo ignored while sending
  wire sir_seen = sir && sir_tick && !sir_s && tx_st_q == TX_IDLE;
  always @(posedge aclk) begin
    if (!aresetn) begin
      str_q <= 5'h00;
    end else if (sir_seen) begin
      str_q <= `SIR_STRETCH;
    end else if (tick && str_q != 5'h00) begin
      str_q <= str_q - 5'h01;
    end
  end
  // infrared input feeds receiver in SIR
  wire line = sir ? (str_q == 5'h00) : rx_s;
  wire [7:0] rx_data = (rx_sh_q >> (2'h3 - dbits)) & dmask;
  wire rx_perr = par_en && (rx_par_q != (^rx_data ^ !lcr_q[`LCR_EVEN]));
  assign rx_busy = rx_st_q != RX_IDLE;
  assign rx_push = (rx_st_q == RX_STOP) && tick && rx_tick_q == `TICK_LAST;
  // all zeros and low stop is a break
  assign rx_word = {rx_zero_q && !line, !line, rx_perr, rx_data};
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= RX_IDLE;
      rx_bit_q <= 3'h0;
      rx_tick_q <= 4'h0;
      rx_sh_q <= `RST_BYTE;
      rx_par_q <= 1'b0;
      rx_zero_q <= 1'b0;
    end else begin
      if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (tick && !line) begin
            rx_tick_q <= 4'h0;
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_tick_q == `TICK_MID) begin
            rx_tick_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_zero_q <= 1'b1;
            rx_st_q <= line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (tick && rx_tick_q == `TICK_LAST) begin
            rx_sh_q <= {line, rx_sh_q[7:1]};
            rx_zero_q <= rx_zero_q && !line;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_st_q <= par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (tick && rx_tick_q == `TICK_LAST) begin
            rx_par_q <= line;
            rx_zero_q <= rx_zero_q && !line;
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_push) begin
            rx_st_q <= line ? RX_IDLE : RX_BRK;
          end
        end
        RX_BRK: begin
          if (line) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Line status, timeout and identification
  // ------------------------------------------------------------
  reg ovr_q, perr_q, ferr_q, brk_q, tx_holding_empty_int_q, tx_holding_empty_cond_q;
  reg [9:0] to_cnt_q;
  // Start, data (last index plus one), parity, and one or two stops
  wire [3:0] char_bits = {1'b0, last_bit} + 4'h3 + {3'h0, par_en} + {3'h0, stop2};
  wire [9:0] to_limit = {char_bits, 6'h00};
  wire [PW:0] rx_trig = (rx_trig_q == 2'h0) ? {{PW{1'b0}}, 1'b1} : (rx_trig_q == 2'h1) ? DEPTH >> 2 :
    (rx_trig_q == 2'h2) ? DEPTH >> 1 : DEPTH - {{(PW-1){1'b0}}, 2'h2};
  wire [PW:0] tx_thr = (tx_thr_q == 2'h0) ? {(PW+1){1'b0}} : (tx_thr_q == 2'h1) ? {{(PW-1){1'b0}}, 2'h2} :
    (tx_thr_q == 2'h2) ? DEPTH >> 2 : DEPTH >> 1;
  wire prog_tx_holding_empty = ier_q[`IER_PTIME] && fifo_en_q;
  wire tx_holding_empty_cond = prog_tx_holding_empty ? (tx_cnt_q <= tx_thr) : tx_empty;
  wire line_err = ovr_q || perr_q || ferr_q || brk_q;
  wire rda = fifo_en_q ? (rx_cnt_q >= rx_trig) : !rx_empty;
  wire timeout = fifo_en_q && !rx_empty && to_cnt_q >= to_limit;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      brk_q <= 1'b0;
      tx_holding_empty_int_q <= 1'b0;
      tx_holding_empty_cond_q <= 1'b0;
      to_cnt_q <= 10'h000;
    end else begin
      // Error flags: a new event wins over the clearing read
      ovr_q <= (rx_push && rx_full) || (ovr_q && !rd_lsr);
      perr_q <= (rx_take && rx_word[8]) || (perr_q && !rd_lsr);
      ferr_q <= (rx_take && rx_word[9]) || (ferr_q && !rd_lsr);
      brk_q <= (rx_take && rx_word[10]) || (brk_q && !rd_lsr);
      tx_holding_empty_cond_q <= tx_holding_empty_cond;
      tx_holding_empty_int_q <= (tx_holding_empty_cond && !tx_holding_empty_cond_q) || (tx_holding_empty_int_q && !rd_iir && !wr_data);
      // four character times without FIFO activity
      if (rx_empty || rx_take || rx_pop) begin
        to_cnt_q <= 10'h000;
      end else if (tick && to_cnt_q < to_limit) begin
        to_cnt_q <= to_cnt_q + 10'h001;
      end
    end
  end
  wire [3:0] iid = (line_err && ier_q[`IER_LSI]) ? `IID_LINE : (rda && ier_q[`IER_RDA]) ? `IID_RDA :
    (timeout && ier_q[`IER_RDA]) ? `IID_TIMEOUT : (tx_holding_empty_int_q && tx_holding_empty_cond && ier_q[`IER_TX_HOLDING_EMPTY]) ? `IID_TX_HOLDING_EMPTY :
    `IID_NONE;
  // status bit shows full in threshold mode
  wire lsr5 = prog_tx_holding_empty ? tx_full : tx_empty;
  wire [7:0] line_status_reg = {line_err || perr_q, tx_empty && tx_st_q == TX_IDLE, lsr5, brk_q, ferr_q, perr_q, ovr_q,
    !rx_empty};

  // ------------------------------------------------------------
  // Register writes and flow control output
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_byte_q <= `RST_BYTE;
      w_en_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      ier_q <= `RST_BYTE;
      lcr_q <= `RST_BYTE;
      mcr_q <= `RST_BYTE;
      dll_q <= `RST_BYTE;
      dlh_q <= `RST_BYTE;
      dlf_q <= 4'h0;
      lpl_q <= `RST_BYTE;
      lph_q <= `RST_BYTE;
      fifo_en_q <= 1'b0;
      rx_trig_q <= 2'h0;
      tx_thr_q <= 2'h0;
      rts_n <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_en_q <= wstrb[0];
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (wr_hit) begin
        case (aw_addr_q)
          `OFS_IER: ier_q <= w_byte_q;
          `OFS_IIR_FCR: begin
            fifo_en_q <= w_byte_q[`FCR_FIFO_EN];
            tx_thr_q <= w_byte_q[5:4];
            rx_trig_q <= w_byte_q[7:6];
          end
          // length field sets five to eight
          `OFS_LCR: lcr_q <= w_byte_q;
          `OFS_MCR: mcr_q <= w_byte_q;
          `OFS_DLL: dll_q <= w_byte_q;
          `OFS_DLH: dlh_q <= w_byte_q;
          `OFS_DLF: dlf_q <= w_byte_q[3:0];
          `OFS_LPL: lpl_q <= w_byte_q;
          `OFS_LPH: lph_q <= w_byte_q;
          default: ;
        endcase
      end
      // with automatic flow control on, RTS drops when receive buffer reaches trigger
      rts_n <= !(mcr_q[`MCR_RTS] && !(autoflow && rx_cnt_q >= rx_trig));
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (araddr)
      `OFS_DATA: rd_byte = rx_empty ? 8'h00 : rx_head[7:0];
      `OFS_IER: rd_byte = ier_q;
      `OFS_IIR_FCR: rd_byte = {fifo_en_q, fifo_en_q, 2'h0, iid};
      `OFS_LCR: rd_byte = lcr_q;
      `OFS_MCR: rd_byte = mcr_q;
      `OFS_LSR: rd_byte = line_status_reg;
      `OFS_DLL: rd_byte = dll_q;
      `OFS_DLH: rd_byte = dlh_q;
      `OFS_DLF: rd_byte = {4'h0, dlf_q};
      `OFS_LPL: rd_byte = lpl_q;
      `OFS_LPH: rd_byte = lph_q;
      `OFS_MSR: rd_byte = {3'h0, !cts_n_s, 2'h0, rx_busy, tx_st_q != TX_IDLE};
      default: rd_byte = 8'h00;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_ok ? rd_byte : 8'h00};
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ===== tb/sir_uart_properties.sv
// Register bus handshake and infrared pin checker for the serial port.
// Bound to sir_uart; sees only its ports.
`timescale 1ns/10ps
module sir_uart_check (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire tx_out,
  input wire sir_out_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
  ar_block_a: assert property (rvalid |-> !arready) else $error("arready high");
  r_latency_a: assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
  b_latency_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid)
    else $error("no bvalid");
  aw_hold_a: assert property (awvalid && awready |=> !awready) else $error("awready high");
  w_hold_a: assert property (wvalid && wready |=> !wready) else $error("wready high");
  byte_lane_a: assert property (rvalid |-> rdata[31:8] == 24'h000000) else $error("upper bits");
  sir_quiet_a: assert property (!sir_out_n |-> tx_out) else $error("serial pin active in infrared mode");
endmodule

bind sir_uart sir_uart_check chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .tx_out(tx_out), .sir_out_n(sir_out_n));

// ===== tb/serial_peer.sv
// Remote serial sender feeding the receive pin; it waits while RTS is inactive.
// Assumes divisor 1, so one bit is 16 aclk cycles.
`timescale 1ns/10ps
module serial_peer (
  input wire aclk,
  input wire rts_n,
  output reg line
);
  integer j;
  reg [9:0] frame;
  initial line = 1'h1;
  task send(input [7:0] b);
    begin
      while (rts_n) @(posedge aclk);
      frame = {1'h1, b, 1'h0};
      for (j = 0; j < 10; j = j + 1) begin
        line <= frame[j];
        repeat (16) @(posedge aclk);
      end
    end
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench: register bus, framing, receive order, flow control, infrared coding.
// Assumes divisor 1 so a bit lasts 16 aclk cycles.
`timescale 1ns/10ps
`include "uart_defines.vh"
module testbench;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [5:0] awaddr = 6'h00, araddr = 6'h00;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hF;
  reg cts_n = 1'h0, sir_in = 1'h1, fa, fw, fb;
  wire awready, wready, bvalid, arready, rvalid, tx_out, sir_out_n, rts_n, baudout_n, rx_in;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer err_count = 0, checked = 0, seed = 32'hC5DC, i, k, n;
  reg [31:0] got;
  reg [7:0] d, char_format_ctrl;
  reg [9:0] e;
  reg [1:0] resp;
  reg [7:0] q[$];
  always #12.5 aclk = ~aclk;
  sir_uart DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_in(rx_in), .tx_out(tx_out), .sir_in(sir_in),
    .sir_out_n(sir_out_n), .cts_n(cts_n), .rts_n(rts_n), .baudout_n(baudout_n));
  serial_peer peer (.aclk(aclk), .rts_n(rts_n), .line(rx_in));
  task chk(input [31:0] s, input [31:0] x);
    begin
      checked = checked + 1;
      if (s !== x) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d mismatches=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Ready lines are sampled at the falling edge, away from the updating edge
  task wr(input [5:0] a, input [7:0] v);
    begin
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      fb = 1'h0;
      while (!fb) begin
        @(negedge aclk);
        fa = awready;
        fw = wready;
        fb = bvalid;
        @(posedge aclk);
        if (fa) awvalid <= 1'h0;
        if (fw) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task rd(input [5:0] a, output [31:0] v, output [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      fb = 1'h0;
      while (!fb) begin
        @(negedge aclk);
        fa = arready;
        fb = rvalid;
        v = rdata;
        r = rresp;
        @(posedge aclk);
        if (fa) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`OFS_LCR, got, resp);
    chk(got, 32'h0);
    rd(6'h30, got, resp);
    chk(resp, `RESP_SLVERR);
    wr(`OFS_DLL, 8'h01);
    repeat (8) @(posedge aclk);
    $display("registers done");
    for (k = 0; k < 4; k = k + 1) begin
      d = $random(seed);
      char_format_ctrl = $random(seed);
      char_format_ctrl = {3'h0, char_format_ctrl[4:3], 1'h0, k[1:0]};
      wr(`OFS_LCR, char_format_ctrl);
      wr(`OFS_DATA, d);
      n = 5 + k;
      e = d & ((1 << n) - 1);
      while (tx_out !== 1'h0) @(negedge aclk);
      repeat (8) @(negedge aclk);
      chk(tx_out, 1'h0);
      for (i = 0; i < n; i = i + 1) begin
        repeat (16) @(negedge aclk);
        chk(tx_out, e[i]);
      end
      if (char_format_ctrl[3]) begin
        repeat (16) @(negedge aclk);
        chk(tx_out, ^e ^ !char_format_ctrl[4]);
      end
      repeat (16) @(negedge aclk);
      chk(tx_out, 1'h1);
      @(posedge aclk);
    end
    $display("transmit done");
    wr(`OFS_IIR_FCR, 8'h01);
    wr(`OFS_LCR, 8'h03);
    wr(`OFS_MCR, 8'h02);
    @(negedge aclk);
    chk(rts_n, 1'h0);
    @(posedge aclk);
    for (k = 0; k < 3; k = k + 1) begin
      d = $random(seed);
      q.push_back(d);
      peer.send(d);
    end
    repeat (16) @(posedge aclk);
    // Three characters stand above the trigger of one, so automatic flow control deasserts RTS
    wr(`OFS_MCR, 8'h22);
    @(negedge aclk);
    chk(rts_n, 1'h1);
    @(posedge aclk);
    while (q.size() > 0) begin
      rd(`OFS_DATA, got, resp);
      chk(got, {24'h0, q.pop_front()});
    end
    @(negedge aclk);
    chk(rts_n, 1'h0);
    @(posedge aclk);
    $display("receive done");
    // An inactive CTS must hold back a queued all-zero character
    cts_n <= 1'h1;
    wr(`OFS_MCR, 8'h20);
    wr(`OFS_DATA, 8'h00);
    repeat (40) @(negedge aclk);
    chk(tx_out, 1'h1);
    @(posedge aclk);
    cts_n <= 1'h0;
    repeat (180) @(posedge aclk);
    rd(`OFS_LSR, got, resp);
    chk(got[6], 1'h1);
    $display("flow control done");
    // nothing is received after the infrared send
    // Five bits with parity asked for; infrared mode must keep eight bits, no parity
    wr(`OFS_MCR, 8'h40);
    wr(`OFS_LCR, 8'h0C);
    d = $random(seed);
    wr(`OFS_DATA, d);
    e = {1'h1, d, 1'h0};
    while (sir_out_n !== 1'h0) @(negedge aclk);
    for (i = 0; i < 10; i = i + 1) begin
      n = 0;
      repeat (16) begin
        n = n + !sir_out_n;
        @(negedge aclk);
      end
      chk(n, e[i] ? 0 : 3);
    end
    $display("infrared done");
    complete_run;
  end
endmodule
